// file: dmaag_pkg.sv
// Purpose: Shared constants for the DMA address generation block.
// Assumes: APB word addressing; register index times four is the byte address.
// Notes:   Command entry layout is used by the producer and by the consumer.
package dmaag_pkg;
    localparam int unsigned PADDR_W = 14;
    // Register indices; the APB byte address is four times the index.
    localparam logic [11:0] CH0_CTRL_IDX  = 12'hfb0;
    localparam logic [11:0] CH0_IO_IDX    = 12'hfb1;
    localparam logic [11:0] CH0_HI_IDX    = 12'hfb2;
    localparam logic [11:0] CH0_START_IDX = 12'hfb3;
    localparam logic [11:0] CH0_END_IDX   = 12'hfb4;
    localparam logic [11:0] CH1_CTRL_IDX  = 12'hfb8;
    localparam logic [11:0] CH1_IO_IDX    = 12'hfb9;
    localparam logic [11:0] CH1_HI_IDX    = 12'hfba;
    localparam logic [11:0] CH1_START_IDX = 12'hfbb;
    localparam logic [11:0] CH1_END_IDX   = 12'hfbc;
    localparam logic [11:0] ADC_BASE_IDX  = 12'hfbd;
    localparam logic [11:0] ADC_CTRL_IDX  = 12'hfbe;
    // Register selectors produced by the address decoder.
    localparam logic [2:0] SEL_CTRL  = 3'h0;
    localparam logic [2:0] SEL_IO    = 3'h1;
    localparam logic [2:0] SEL_HI    = 3'h2;
    localparam logic [2:0] SEL_START = 3'h3;
    localparam logic [2:0] SEL_END   = 3'h4;
    localparam logic [2:0] SEL_ABASE = 3'h5;
    localparam logic [2:0] SEL_ACTRL = 3'h6;
    localparam logic [2:0] SEL_NONE  = 3'h7;
    // Channel control fields.
    localparam int unsigned CTRL_EN_BIT   = 7;
    localparam int unsigned CTRL_LOOP_BIT = 6;
    localparam int unsigned CTRL_DIR_BIT  = 5;
    localparam int unsigned CTRL_IE_BIT   = 4;
    localparam int unsigned CTRL_WORD_BIT = 3;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    // ADC control fields.
    localparam int unsigned ACTRL_EN_BIT  = 7;
    localparam int unsigned ACTRL_IE_BIT  = 6;
    localparam int unsigned ACTRL_CNT_LSB = 0;
    localparam logic [7:0]  ACTRL_RESET   = 8'h00;
    localparam logic [3:0]  PERIPH_PAGE   = 4'hf;
    localparam logic [11:0] STEP_BYTE     = 12'h001;
    localparam logic [11:0] STEP_WORD     = 12'h002;
    // Command entry: kind, memory address, peripheral address, dir, word, data.
    localparam logic [1:0] KIND_CH0 = 2'h0;
    localparam logic [1:0] KIND_CH1 = 2'h1;
    localparam logic [1:0] KIND_ADC = 2'h2;
    localparam int unsigned CMD_KIND_LSB  = 42;
    localparam int unsigned CMD_MEM_LSB   = 30;
    localparam int unsigned CMD_PERI_LSB  = 18;
    localparam int unsigned CMD_DIR_BIT   = 17;
    localparam int unsigned CMD_WORD_BIT  = 16;
    localparam int unsigned CMD_W         = 44;
    localparam int unsigned FIFO_DEPTH    = 8;
endpackage

// file: dmaag_top.sv
// Purpose: Address generation for two DMA channels and an ADC result channel.
// Assumes: Single clock pclk, async active-low presetn, APB register access.
// Notes:   Operation list follows; commands are drained by cmd_valid/ready.
// Operation
// - Peripheral address is page F above the programmed peripheral byte.
// - High-nibble register gives end bits from [7:4], start from [3:0].
// - Writing the start low byte loads the start address.
// - Current address steps by one for bytes, two for words.
// - Reading the start low byte returns the current address low byte.
// - End high nibble and end low byte form the 12-bit end address.
// - ADC storage address top seven bits come from base bits [7:1].
// - ADC low five bits are twice the analog input number.
// - ADC result goes out as two bytes, high byte at even address.
// - Peripheral byte selects only within page F00 to FFF.
// - After end transfer reload start; without loop the channel disables.
// - Word select chooses byte or two-byte word per request.
// - With interrupt enable set, end transfer raises an interrupt pulse.
// - ADC steps to the next input, wrapping to zero after the last.
//
// Implementation choice: the APB interface to the registers.

module dmaag_fifo #(
    parameter int WIDTH = 44,
    parameter int DEPTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [PW:0]                 cnt;
    } dmaag_fifo_state_type;

    dmaag_fifo_state_type state_reg;
    dmaag_fifo_state_type state_next;
    logic                 push;
    logic                 pop;

    assign in_ready  = state_reg.cnt != (PW+1)'(DEPTH);
    assign out_valid = state_reg.cnt != '0;
    assign out_data  = state_reg.mem[state_reg.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        state_next = state_reg;
        if (push)
        begin
            state_next.mem[state_reg.wp] = in_data;
            state_next.wp = state_reg.wp + 1'b1;
        end
        if (pop)
            state_next.rp = state_reg.rp + 1'b1;
        unique case ({push, pop})
            2'b10:   state_next.cnt = state_reg.cnt + 1'b1;
            2'b01:   state_next.cnt = state_reg.cnt - 1'b1;
            default: state_next.cnt = state_reg.cnt;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end
endmodule

module dmaag_top (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [dmaag_pkg::PADDR_W-1:0] paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [1:0]                    ch_request,
    input  wire logic                          adc_result_valid,
    input  wire logic [9:0]                    adc_result,
    output logic      [3:0]                    adc_input_sel,
    output logic                               adc_convert_start,
    output logic                               cmd_valid,
    input  wire logic                          cmd_ready,
    output logic      [dmaag_pkg::CMD_W-1:0]   cmd_data,
    output logic      [1:0]                    ch_irq,
    output logic                               adc_irq
);
    typedef struct packed {
        logic [1:0][7:0]  ctrl;
        logic [1:0][7:0]  io;
        logic [1:0][7:0]  hi;
        logic [1:0][7:0]  start_lo;
        logic [1:0][7:0]  end_lo;
        logic [1:0][11:0] cur;
        logic [1:0]       pend;
        logic [7:0]       adc_base;
        logic [7:0]       adc_ctrl;
        logic [3:0]       adc_num;
        logic             adc_pend;
        logic [9:0]       adc_data;
        logic             adc_start;
        logic [31:0]      rdata;
        logic [1:0]       irq;
        logic             adc_irq;
    } dmaag_state_type;

    dmaag_state_type             state_reg;
    dmaag_state_type             state_next;
    logic [1:0]                  take;
    logic                        take_adc;
    logic [1:0]                  last;
    logic                        push_valid;
    logic                        push_ready;
    logic [dmaag_pkg::CMD_W-1:0] push_data;
    logic [3:0]                  dec;
    logic                        apb_wr;
    logic                        apb_rd;
    logic [11:0]                 adc_addr;

    // Maps a word index to {channel, selector}; shared by reads and writes.
    function automatic logic [3:0] decode(input logic [11:0] idx);
        logic [3:0] d;
        unique case (idx)
            dmaag_pkg::CH0_CTRL_IDX:  d = {1'b0, dmaag_pkg::SEL_CTRL};
            dmaag_pkg::CH0_IO_IDX:    d = {1'b0, dmaag_pkg::SEL_IO};
            dmaag_pkg::CH0_HI_IDX:    d = {1'b0, dmaag_pkg::SEL_HI};
            dmaag_pkg::CH0_START_IDX: d = {1'b0, dmaag_pkg::SEL_START};
            dmaag_pkg::CH0_END_IDX:   d = {1'b0, dmaag_pkg::SEL_END};
            dmaag_pkg::CH1_CTRL_IDX:  d = {1'b1, dmaag_pkg::SEL_CTRL};
            dmaag_pkg::CH1_IO_IDX:    d = {1'b1, dmaag_pkg::SEL_IO};
            dmaag_pkg::CH1_HI_IDX:    d = {1'b1, dmaag_pkg::SEL_HI};
            dmaag_pkg::CH1_START_IDX: d = {1'b1, dmaag_pkg::SEL_START};
            dmaag_pkg::CH1_END_IDX:   d = {1'b1, dmaag_pkg::SEL_END};
            dmaag_pkg::ADC_BASE_IDX:  d = {1'b0, dmaag_pkg::SEL_ABASE};
            dmaag_pkg::ADC_CTRL_IDX:  d = {1'b0, dmaag_pkg::SEL_ACTRL};
            default:                  d = {1'b0, dmaag_pkg::SEL_NONE};
        endcase
        return d;
    endfunction

    // End address of a channel, used by the compare that sets last.
    function automatic logic [11:0] end_addr(input logic [7:0] hi,
                                             input logic [7:0] lo);
        return {hi[7:4], lo};
    endfunction

    assign dec = paddr[1:0] == 2'h0 ? decode(paddr[13:2])
                                    : {1'b0, dmaag_pkg::SEL_NONE};
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    // Zero wait states: read data is captured in the setup cycle.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && dec[2:0] == dmaag_pkg::SEL_NONE;
    assign prdata  = state_reg.rdata;
    assign adc_input_sel     = state_reg.adc_num;
    assign adc_convert_start = state_reg.adc_start;
    assign ch_irq  = state_reg.irq;
    assign adc_irq = state_reg.adc_irq;
    // Bit 0 of the base is ignored, so a stray one there cannot shift data.
    assign adc_addr = {state_reg.adc_base[7:1], state_reg.adc_num, 1'b0};

    always_comb
    begin
        state_next = state_reg;
        state_next.irq = '0;
        state_next.adc_irq = 1'b0;
        state_next.adc_start = 1'b0;
        take = '0;
        take_adc = 1'b0;
        push_data = '0;
        // Fixed priority: channel 0, channel 1, then ADC results.
        if (state_reg.pend[0] && state_reg.ctrl[0][dmaag_pkg::CTRL_EN_BIT])
            take[0] = push_ready;
        else if (state_reg.pend[1]
                 && state_reg.ctrl[1][dmaag_pkg::CTRL_EN_BIT])
            take[1] = push_ready;
        else if (state_reg.adc_pend)
            take_adc = push_ready;

        for (int c = 0; c < 2; c++)
        begin
            last[c] = state_reg.cur[c]
                      == end_addr(state_reg.hi[c], state_reg.end_lo[c]);
            if (take[c])
            begin
                push_data = {c[1:0], state_reg.cur[c],
                             dmaag_pkg::PERIPH_PAGE, state_reg.io[c],
                             state_reg.ctrl[c][dmaag_pkg::CTRL_DIR_BIT],
                             state_reg.ctrl[c][dmaag_pkg::CTRL_WORD_BIT],
                             16'h0000};
                if (last[c])
                begin
                    state_next.cur[c] = {state_reg.hi[c][3:0],
                                         state_reg.start_lo[c]};
                    if (!state_reg.ctrl[c][dmaag_pkg::CTRL_LOOP_BIT])
                        state_next.ctrl[c][dmaag_pkg::CTRL_EN_BIT] = 1'b0;
                    state_next.irq[c] =
                        state_reg.ctrl[c][dmaag_pkg::CTRL_IE_BIT];
                end
                else if (state_reg.ctrl[c][dmaag_pkg::CTRL_WORD_BIT])
                    state_next.cur[c] = state_reg.cur[c]
                                        + dmaag_pkg::STEP_WORD;
                else
                    state_next.cur[c] = state_reg.cur[c]
                                        + dmaag_pkg::STEP_BYTE;
            end
            // A request in the same cycle as its take is kept pending.
            state_next.pend[c] = (state_reg.pend[c] && !take[c]
                                  || ch_request[c])
                                 && state_reg.ctrl[c][dmaag_pkg::CTRL_EN_BIT];
        end

        if (take_adc)
        begin
            push_data = {dmaag_pkg::KIND_ADC, adc_addr, 12'h000, 1'b1, 1'b1,
                         6'h00, state_reg.adc_data};
            state_next.adc_pend = 1'b0;
            state_next.adc_start = 1'b1;
            if (state_reg.adc_num
                >= state_reg.adc_ctrl[dmaag_pkg::ACTRL_CNT_LSB +: 4])
            begin
                state_next.adc_num = 4'h0;
                state_next.adc_irq =
                    state_reg.adc_ctrl[dmaag_pkg::ACTRL_IE_BIT];
            end
            else
                state_next.adc_num = state_reg.adc_num + 1'b1;
        end
        if (adc_result_valid)
        begin
            state_next.adc_pend = 1'b1;
            state_next.adc_data = adc_result;
        end
        if (!state_reg.adc_ctrl[dmaag_pkg::ACTRL_EN_BIT])
        begin
            state_next.adc_pend = 1'b0;
            state_next.adc_num = 4'h0;
        end

        // Software writes win over a transfer's update in the same cycle.
        if (apb_wr)
        begin
            unique case (dec[2:0])
                dmaag_pkg::SEL_CTRL:  state_next.ctrl[dec[3]] = pwdata[7:0];
                dmaag_pkg::SEL_IO:    state_next.io[dec[3]] = pwdata[7:0];
                dmaag_pkg::SEL_HI:
                begin
                    state_next.hi[dec[3]] = pwdata[7:0];
                    state_next.cur[dec[3]][11:8] = pwdata[3:0];
                end
                dmaag_pkg::SEL_START:
                begin
                    state_next.start_lo[dec[3]] = pwdata[7:0];
                    state_next.cur[dec[3]][7:0] = pwdata[7:0];
                end
                dmaag_pkg::SEL_END:   state_next.end_lo[dec[3]] = pwdata[7:0];
                dmaag_pkg::SEL_ABASE: state_next.adc_base = pwdata[7:0];
                dmaag_pkg::SEL_ACTRL:
                begin
                    state_next.adc_ctrl = pwdata[7:0];
                    state_next.adc_start = pwdata[dmaag_pkg::ACTRL_EN_BIT]
                        && !state_reg.adc_ctrl[dmaag_pkg::ACTRL_EN_BIT];
                end
                default:              state_next.adc_base = state_reg.adc_base;
            endcase
        end

        if (apb_rd)
        begin
            unique case (dec[2:0])
                dmaag_pkg::SEL_CTRL:  state_next.rdata = {24'h00_0000,
                                                      state_reg.ctrl[dec[3]]};
                dmaag_pkg::SEL_IO:    state_next.rdata = {24'h00_0000,
                                                      state_reg.io[dec[3]]};
                dmaag_pkg::SEL_HI:    state_next.rdata = {24'h00_0000,
                                                      state_reg.hi[dec[3]]};
                dmaag_pkg::SEL_START: state_next.rdata = {24'h00_0000,
                                        state_reg.cur[dec[3]][7:0]};
                dmaag_pkg::SEL_END:   state_next.rdata = {24'h00_0000,
                                                      state_reg.end_lo[dec[3]]};
                dmaag_pkg::SEL_ABASE: state_next.rdata = {24'h00_0000,
                                                      state_reg.adc_base};
                dmaag_pkg::SEL_ACTRL: state_next.rdata = {24'h00_0000,
                                                      state_reg.adc_ctrl};
                default:              state_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    assign push_valid = |take || take_adc;

    // Register contents are not meaningful until written; cleared anyway.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    dmaag_fifo #(
        .WIDTH (dmaag_pkg::CMD_W),
        .DEPTH (dmaag_pkg::FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (cmd_valid),
        .out_ready (cmd_ready),
        .out_data  (cmd_data)
    );

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    periph_page_a: assert property (
        take[0] |-> push_data[29:18] == {4'hf, state_reg.io[0]})
        else $error("peripheral address not in top page");
    adc_addr_a: assert property (
        take_adc |-> push_data[41:30]
            == {state_reg.adc_base[7:1], state_reg.adc_num, 1'b0})
        else $error("ADC storage address wrong");
    step_word_a: assert property (
        take[1] && !last[1] && state_reg.ctrl[1][3] && !apb_wr
        |=> state_reg.cur[1] == $past(state_reg.cur[1]) + 12'h002)
        else $error("word step not two");
    reload_a: assert property (
        take[1] && last[1] && !apb_wr
        |=> state_reg.cur[1] == {state_reg.hi[1][3:0], state_reg.start_lo[1]})
        else $error("start address not reloaded");
    loop_off_a: assert property (
        take[0] && last[0] && !state_reg.ctrl[0][6] && !apb_wr
        |=> !state_reg.ctrl[0][7] ##1 !take[0])
        else $error("channel still enabled after end");
    end_irq_a: assert property (
        take[0] && last[0] && state_reg.ctrl[0][4] |=> ch_irq[0] ##1 !ch_irq[0])
        else $error("end interrupt pulse missing");
    start_write_a: assert property (
        apb_wr && dec == {1'b0, dmaag_pkg::SEL_START}
        |=> state_reg.cur[0][7:0] == $past(pwdata[7:0]))
        else $error("start write not loaded");
    read_cur_a: assert property (
        apb_rd && dec == {1'b0, dmaag_pkg::SEL_START}
        |=> prdata[7:0] == $past(state_reg.cur[0][7:0]))
        else $error("start read not current address");
    adc_wrap_a: assert property (
        take_adc && state_reg.adc_num >= state_reg.adc_ctrl[3:0]
        && !apb_wr |=> state_reg.adc_num == 4'h0 && adc_convert_start)
        else $error("ADC input did not wrap");
endmodule

// file: dmaag_partner.sv
// Purpose: Far-side model: command consumer and ADC converter.
// Assumes: Every output changes just after a rising edge of pclk.
// Notes:   Each result carries its input number so the bench can predict it.
module dmaag_partner (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       hold,
    input  wire logic       adc_convert_start,
    input  wire logic [3:0] adc_input_sel,
    output logic            adc_result_valid,
    output logic      [9:0] adc_result,
    output logic            cmd_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    int         wait_cnt;
    logic [3:0] chan;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_cnt <= 0;
            chan <= 4'h0;
            adc_result_valid <= 1'b0;
            adc_result <= 10'h000;
            cmd_ready <= 1'b0;
        end
        else
        begin
            cmd_ready <= !hold;
            adc_result_valid <= (wait_cnt == 1);
            // Outside a result the data toggles, so stale values get caught.
            adc_result <= (wait_cnt == 1) ? {6'h2a, chan} : ~adc_result;
            if (adc_convert_start)
            begin
                wait_cnt <= 20;
                chan <= adc_input_sel;
            end
            else if (wait_cnt != 0)
                wait_cnt <= wait_cnt - 1;
        end
    end
endmodule

// file: tb_dmaag_top.sv
// Purpose: Self-checking bench for the DMA address generation block.
// Assumes: Zero-wait APB; partner pops commands unless held.
// Notes:   Popped commands are queued by a monitor and judged in order.
module tb_dmaag_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, hold, err;
    logic        pready, pslverr, adc_result_valid, adc_irq;
    logic        adc_convert_start, cmd_valid, cmd_ready;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  ch_request, ch_irq;
    logic [9:0]  adc_result;
    logic [3:0]  adc_input_sel;
    logic [43:0] cmd_data, c, e;
    logic [43:0] got[$];
    int          fails, num_checks, irq0, irq1, irqa;
    dmaag_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ch_request(ch_request), .adc_result_valid(adc_result_valid),
        .adc_result(adc_result), .adc_input_sel(adc_input_sel),
        .adc_convert_start(adc_convert_start), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_data(cmd_data), .ch_irq(ch_irq),
        .adc_irq(adc_irq));
    dmaag_partner i_far (.pclk(pclk), .presetn(presetn), .hold(hold),
        .adc_convert_start(adc_convert_start), .adc_input_sel(adc_input_sel),
        .adc_result_valid(adc_result_valid), .adc_result(adc_result),
        .cmd_ready(cmd_ready));
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        if (cmd_valid === 1'b1 && cmd_ready === 1'b1)
            got.push_back(cmd_data);
        irq0 += (ch_irq[0] === 1'b1);
        irq1 += (ch_irq[1] === 1'b1);
        irqa += (adc_irq === 1'b1);
    end
    task automatic check(input logic [43:0] seen, input logic [43:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [43:0] cmd(logic [1:0] k, logic [11:0] m,
        logic [11:0] p, logic d, logic w, logic [15:0] x);
        return {k, m, p, d, w, x};
    endfunction
    task automatic apb(input logic wr, input logic [11:0] idx,
        input logic [7:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            fails++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic req(input int ch);
        @(posedge pclk);
        ch_request[ch] <= 1'b1;
        @(posedge pclk);
        ch_request[ch] <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic take(output logic [43:0] t);
        int n;
        n = 0;
        while (got.size() == 0 && n < 200)
        begin
            @(posedge pclk);
            n++;
        end
        t = (got.size() > 0) ? got.pop_front() : 'x;
    endtask
    task automatic test_unmapped;
        apb(1'b0, 12'h000, 8'h00);
        check(err, 1'b1);
        check(rd, 32'h0000_0000);
    endtask
    task automatic test_ch0;
        apb(1'b1, dmaag_pkg::CH0_IO_IDX, 8'h34);
        apb(1'b1, dmaag_pkg::CH0_HI_IDX, 8'h21);
        apb(1'b1, dmaag_pkg::CH0_START_IDX, 8'hfe);
        apb(1'b1, dmaag_pkg::CH0_END_IDX, 8'h00);
        apb(1'b1, dmaag_pkg::CH0_CTRL_IDX, 8'hb0);
        req(0);
        take(c);
        e = cmd(dmaag_pkg::KIND_CH0, 12'h1fe, 12'hf34, 1'b1, 1'b0, 16'h0);
        check(c, e);
        apb(1'b0, dmaag_pkg::CH0_START_IDX, 8'h00);
        check(rd[7:0], 8'hff);
        check(err, 1'b0);
        req(0);
        take(c);
        check(c[41:30], 12'h1ff);
        req(0);
        take(c);
        check(c[41:30], 12'h200);
        apb(1'b0, dmaag_pkg::CH0_START_IDX, 8'h00);
        check(rd[7:0], 8'hfe);
        check(irq0, 1);
        req(0);
        repeat (10) @(posedge pclk);
        check(got.size(), 0);
    endtask
    task automatic test_ch1;
        apb(1'b1, dmaag_pkg::CH1_IO_IDX, 8'h40);
        apb(1'b1, dmaag_pkg::CH1_HI_IDX, 8'h33);
        apb(1'b1, dmaag_pkg::CH1_START_IDX, 8'h10);
        apb(1'b1, dmaag_pkg::CH1_END_IDX, 8'h12);
        apb(1'b1, dmaag_pkg::CH1_CTRL_IDX, 8'hc8);
        for (int i = 0; i < 3; i++)
        begin
            req(1);
            take(c);
            e = cmd(dmaag_pkg::KIND_CH1, (i == 1) ? 12'h312 : 12'h310,
                12'hf40, 1'b0, 1'b1, 16'h0);
            check(c, e);
        end
        check(irq1, 0);
        apb(1'b1, dmaag_pkg::CH1_CTRL_IDX, 8'h00);
    endtask
    task automatic test_adc;
        apb(1'b1, dmaag_pkg::ADC_BASE_IDX, 8'h72);
        apb(1'b1, dmaag_pkg::ADC_CTRL_IDX, 8'hc1);
        for (int i = 0; i < 2; i++)
        begin
            take(c);
            e = cmd(dmaag_pkg::KIND_ADC, 12'h720 + 12'(2 * i), 12'h000,
                1'b1, 1'b1, 16'h02a0 + 16'(i));
            check(c, e);
        end
        check(adc_input_sel, 4'h0);
        apb(1'b1, dmaag_pkg::ADC_CTRL_IDX, 8'h00);
        check(irqa, 1);
        repeat (40) @(posedge pclk);
        got.delete();
    endtask
    task automatic test_fifo;
        hold <= 1'b1;
        apb(1'b1, dmaag_pkg::CH0_HI_IDX, 8'h00);
        apb(1'b1, dmaag_pkg::CH0_START_IDX, 8'h00);
        apb(1'b1, dmaag_pkg::CH0_END_IDX, 8'hff);
        apb(1'b1, dmaag_pkg::CH0_CTRL_IDX, 8'hc0);
        repeat (10) req(0);
        check(cmd_valid, 1'b1);
        check(got.size(), 0);
        hold <= 1'b0;
        repeat (30) @(posedge pclk);
        // Eight entries filled the queue and one request stayed pending.
        check(got.size(), 9);
        for (int i = 0; i < 9; i++)
            check(got[i][41:30], 12'(i));
        apb(1'b1, dmaag_pkg::CH0_CTRL_IDX, 8'h00);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #80000;
        fails++;
        tally_and_finish;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, hold, ch_request} = '0;
        paddr = '0;
        pwdata = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        test_unmapped;
        test_ch0;
        test_ch1;
        test_adc;
        test_fifo;
        tally_and_finish;
    end
endmodule
